// >>> scc_defines.svh
// Constants for the serial configuration command interpreter
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH

// Line framing characters and the echo-on value character
`define SCC_CR 8'h0d
`define SCC_LF 8'h0a
`define SCC_ECHO_ON_CHAR 8'h31

// Two-letter command codes, first letter in the upper byte
`define SCC_PARAM_SP_CMD 16'h5350
`define SCC_ECHO_CONTROL_CMD 16'h4543
`define SCC_LOCAL_IP_CMD 16'h4c49
`define SCC_SAVE_PARAMS_CMD 16'h5356
`define SCC_REBOOT_CMD 16'h5254
`define SCC_EXIT_CONFIG_CMD 16'h4558

// Parameter slots
`define SCC_NUM_PARAMS 3
`define SCC_IDX_SP 2'h0
`define SCC_IDX_EC 2'h1
`define SCC_IDX_LI 2'h2
`define SCC_IDX_NONE 2'h3

// Buffer sizes in characters
`define SCC_VAL_MAX 16
`define SCC_LINE_MAX 18
`define SCC_TX_MAX 20

// Reset values, last character in the low byte
`define SCC_SP_RESET 128'h313130
`define SCC_SP_RESET_LEN 5'h03
`define SCC_EC_RESET 128'h30
`define SCC_EC_RESET_LEN 5'h01
`define SCC_LI_RESET "192.168.11.2"
`define SCC_LI_RESET_LEN 5'h0c

// Reboot display text with its line end
`define SCC_REBOOT_TEXT 64'h5245424f4f540d0a
`define SCC_REBOOT_TEXT_LEN 5'h08

// Default software trigger code
`define SCC_TRIG_CODE 24'h2b2b2b

// Start-up time before the trigger strap is taken
`define SCC_CLK_PERIOD_NS 25
`define SCC_BOOT_TIME_NS 70000000
`define SCC_BOOT_CYCLES (`SCC_BOOT_TIME_NS / `SCC_CLK_PERIOD_NS)

`endif

// >>> scc_pkg.sv
// Types for the serial configuration command interpreter
`include "scc_defines.svh"

package scc_pkg;

  typedef enum logic [1:0] {
    ST_BOOT,
    ST_NORMAL,
    ST_CONFIG
  } scc_mode_type;

  typedef struct packed {
    scc_mode_type mode;
    logic [21:0] boot_cnt;
    logic in_config;
    logic echo_act;
    logic [`SCC_NUM_PARAMS-1:0][`SCC_VAL_MAX-1:0][7:0] pval;
    logic [`SCC_NUM_PARAMS-1:0][4:0] plen;
    logic [`SCC_LINE_MAX-1:0][7:0] lbuf;
    logic [4:0] llen;
    logic lcr;
    logic lbad;
    logic [15:0] trig_sh;
    logic [`SCC_TX_MAX-1:0][7:0] tx_buf;
    logic [4:0] tx_len;
    logic [4:0] tx_idx;
    logic tx_valid;
    logic [7:0] tx_data;
    logic save_req;
    logic reboot_req;
    logic close_conn;
    logic trig_out;
    logic trig_oe;
  } scc_state_type;

endpackage : scc_pkg

// >>> scc_command_mode.sv
// Serial configuration command interpreter with trigger pin handling
`timescale 1ns/1ps
`include "scc_defines.svh"

// Overview of operation
// - Query echoes code, value, CR LF; set silent
// - Save command pulses storage write, no reply
// - Reboot applies echo setting, restarts, prints reboot text
// - Exit command leaves configuration mode silently
// - Enter by strap at reset or code
// - Entering configuration closes network data connection
// - Echo received characters in configuration mode when echo enabled and no response line is pending
// - Pin low while connected, high when closed
// - Pin input at start-up, output afterwards
module scc_command_mode #(
  parameter int INIT_CYCLES = `SCC_BOOT_CYCLES,
  parameter logic [23:0] TRIG_CODE = `SCC_TRIG_CODE
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_ready,
  input wire logic link_up,
  input wire logic config_trigger_pin_in,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic config_trigger_pin_out,
  output logic config_trigger_pin_oe,
  output logic in_config,
  output logic close_conn,
  output logic save_req,
  output logic reboot_req
);
  import scc_pkg::*;

  scc_state_type s;
  scc_state_type next_s;

  // Map a command code to its parameter slot
  function automatic logic [1:0] param_index(input logic [15:0] code);
    case (code)
      `SCC_PARAM_SP_CMD: param_index = `SCC_IDX_SP;
      `SCC_ECHO_CONTROL_CMD: param_index = `SCC_IDX_EC;
      `SCC_LOCAL_IP_CMD: param_index = `SCC_IDX_LI;
      default: param_index = `SCC_IDX_NONE;
    endcase
  endfunction : param_index

  // Decode of the line held, shared by next-state logic and checks
  logic rx_cfg;
  logic line_end;
  logic [15:0] code;
  logic [1:0] pidx;
  logic exec_query;
  logic exec_set;
  logic exec_save;
  logic exec_reboot;
  logic exec_exit;
  logic sw_trig;

  assign rx_cfg = rx_valid && (s.mode == ST_CONFIG);
  assign line_end = rx_cfg && (rx_data == `SCC_LF) && s.lcr && !s.lbad && (s.llen >= 5'h02);
  assign code = (s.llen >= 5'h02) ? {s.lbuf[s.llen - 5'h01], s.lbuf[s.llen - 5'h02]} : 16'h0000;
  assign pidx = param_index(code);
  assign exec_query = line_end && (s.llen == 5'h02) && (pidx != `SCC_IDX_NONE);
  assign exec_set = line_end && (s.llen > 5'h02) && (pidx != `SCC_IDX_NONE);
  assign exec_save = line_end && (s.llen == 5'h02) && (code == `SCC_SAVE_PARAMS_CMD);
  assign exec_reboot = line_end && (s.llen == 5'h02) && (code == `SCC_REBOOT_CMD);
  assign exec_exit = line_end && (s.llen == 5'h02) && (code == `SCC_EXIT_CONFIG_CMD);
  assign sw_trig = rx_valid && (s.mode == ST_NORMAL) && ({s.trig_sh, rx_data} == TRIG_CODE);

  // Next state; a response line owns the transmitter until it is sent
  always_comb begin
    next_s = s;
    next_s.save_req = 1'b0;
    next_s.reboot_req = 1'b0;
    next_s.close_conn = 1'b0;
    // Pin reports link state only once start-up is over
    next_s.trig_out = !link_up;
    // Transmit engine
    if (s.tx_valid && tx_ready) begin
      next_s.tx_valid = 1'b0;
    end
    if (!next_s.tx_valid && (s.tx_len != 5'h00)) begin
      if (s.tx_idx == s.tx_len) begin
        next_s.tx_len = 5'h00;
        next_s.tx_idx = 5'h00;
      end else begin
        next_s.tx_valid = 1'b1;
        next_s.tx_data = s.tx_buf[s.tx_len - 5'h01 - s.tx_idx];
        next_s.tx_idx = s.tx_idx + 5'h01;
      end
    end
    case (s.mode)
      ST_BOOT: begin
        // Pin stays an input until the strap has been taken
        next_s.trig_oe = 1'b0;
        next_s.boot_cnt = s.boot_cnt + 22'h000001;
        if (s.boot_cnt == 22'(INIT_CYCLES - 1)) begin
          next_s.boot_cnt = 22'h000000;
          next_s.trig_oe = 1'b1;
          if (!config_trigger_pin_in) begin
            next_s.mode = ST_CONFIG;
            next_s.in_config = 1'b1;
            next_s.close_conn = 1'b1;
          end else begin
            next_s.mode = ST_NORMAL;
          end
        end
      end
      ST_NORMAL: begin
        // Watch the byte stream for the trigger code
        if (rx_valid) begin
          next_s.trig_sh = {s.trig_sh[7:0], rx_data};
        end
        if (sw_trig) begin
          next_s.mode = ST_CONFIG;
          next_s.in_config = 1'b1;
          next_s.close_conn = 1'b1;
          next_s.trig_sh = 16'h0000;
          next_s.llen = 5'h00;
          next_s.lcr = 1'b0;
          next_s.lbad = 1'b0;
        end
      end
      ST_CONFIG: begin
        // Echo only when no response line is pending, so replies never interleave
        if (rx_cfg && s.echo_act && (s.tx_len == 5'h00) && !next_s.tx_valid) begin
          next_s.tx_valid = 1'b1;
          next_s.tx_data = rx_data;
        end
        if (rx_cfg) begin
          if (rx_data == `SCC_LF) begin
            // Any LF closes the line; only a CR LF pair executes, a bare LF drops it
            next_s.llen = 5'h00;
            next_s.lcr = 1'b0;
            next_s.lbad = 1'b0;
          end else if (rx_data == `SCC_CR) begin
            next_s.lcr = 1'b1;
          end else begin
            next_s.lcr = 1'b0;
            if (s.llen == 5'(`SCC_LINE_MAX)) begin
              next_s.lbad = 1'b1;
            end else begin
              next_s.lbuf = {s.lbuf[`SCC_LINE_MAX-2:0], rx_data};
              next_s.llen = s.llen + 5'h01;
            end
          end
        end
        if (exec_query) begin
          next_s.tx_buf = {16'h0000, s.pval[pidx], `SCC_CR, `SCC_LF};
          next_s.tx_buf[s.plen[pidx] + 5'h02] = code[7:0];
          next_s.tx_buf[s.plen[pidx] + 5'h03] = code[15:8];
          next_s.tx_len = s.plen[pidx] + 5'h04;
          next_s.tx_idx = 5'h00;
        end
        if (exec_set) begin
          // Data is the low part of the line; the length bounds what is read
          next_s.pval[pidx] = s.lbuf[`SCC_VAL_MAX-1:0];
          next_s.plen[pidx] = s.llen - 5'h02;
        end
        if (exec_save) begin
          next_s.save_req = 1'b1;
        end
        if (exec_reboot) begin
          next_s.reboot_req = 1'b1;
          next_s.echo_act = (s.pval[`SCC_IDX_EC][0] == `SCC_ECHO_ON_CHAR);
          next_s.tx_buf = {96'h0, `SCC_REBOOT_TEXT};
          next_s.tx_len = `SCC_REBOOT_TEXT_LEN;
          next_s.tx_idx = 5'h00;
          next_s.mode = ST_BOOT;
          next_s.in_config = 1'b0;
          next_s.trig_oe = 1'b0;
        end
        if (exec_exit) begin
          next_s.mode = ST_NORMAL;
          next_s.in_config = 1'b0;
        end
      end
      default: begin
        next_s.mode = ST_BOOT;
      end
    endcase
  end

  // State register; parameters reset to their factory values
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.mode <= ST_BOOT;
      s.trig_out <= 1'b1;
      s.pval[`SCC_IDX_SP] <= `SCC_SP_RESET;
      s.plen[`SCC_IDX_SP] <= `SCC_SP_RESET_LEN;
      s.pval[`SCC_IDX_EC] <= `SCC_EC_RESET;
      s.plen[`SCC_IDX_EC] <= `SCC_EC_RESET_LEN;
      s.pval[`SCC_IDX_LI] <= 128'(`SCC_LI_RESET);
      s.plen[`SCC_IDX_LI] <= `SCC_LI_RESET_LEN;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign tx_valid = s.tx_valid;
  assign tx_data = s.tx_data;
  assign config_trigger_pin_out = s.trig_out;
  assign config_trigger_pin_oe = s.trig_oe;
  assign in_config = s.in_config;
  assign close_conn = s.close_conn;
  assign save_req = s.save_req;
  assign reboot_req = s.reboot_req;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  query_reply_a: assert property (exec_query |=> s.tx_len != 5'h00
    && s.tx_buf[s.tx_len - 5'h01] == $past(code[15:8])) else $error("query reply not queued");
  set_silent_a: assert property (exec_set && s.tx_len == 5'h00 |=> s.tx_len == 5'h00)
    else $error("set command produced a reply");
  save_pulse_a: assert property (save_req |-> $past(exec_save) && s.tx_len == 5'h00)
    else $error("save pulse without save command");
  reboot_text_a: assert property (exec_reboot |=> s.tx_len == `SCC_REBOOT_TEXT_LEN
    && s.mode == ST_BOOT && reboot_req) else $error("reboot did not restart");
  exit_mode_a: assert property (exec_exit |=> s.mode == ST_NORMAL && !in_config)
    else $error("exit command ignored");
  sw_trigger_a: assert property (sw_trig |=> s.mode == ST_CONFIG)
    else $error("trigger code not taken");
  enter_close_a: assert property ($rose(in_config) |-> close_conn)
    else $error("connection not closed on entry");
  echo_back_a: assert property (rx_cfg && s.echo_act && s.tx_len == 5'h00 && !s.tx_valid
    |=> tx_valid && tx_data == $past(rx_data)) else $error("character not echoed");
  link_status_a: assert property (config_trigger_pin_oe && $past(config_trigger_pin_oe)
    |-> config_trigger_pin_out == !$past(link_up)) else $error("status pin wrong");
  pin_input_a: assert property (s.mode == ST_BOOT |=> !config_trigger_pin_oe
    || $past(s.boot_cnt) == 22'(INIT_CYCLES - 1)) else $error("pin driven during start-up");
  partial_line_a: assert property (!line_end |=> !save_req && !reboot_req)
    else $error("acted on incomplete line");

endmodule : scc_command_mode

// >>> scc_host_model.sv
// Host terminal model on the serial side of the command interpreter
`timescale 1ns/1ps
module scc_host_model (
  input wire logic ref_clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data
);
  logic [159:0] acc;
  int n;
  int seed;
  logic stall;
  // Idle line, ready, empty capture at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
    acc = '0;
    n = 0;
    seed = 72;
    stall = 1'b1;
  end
  // Slow receiver: random stalls, never longer than a byte gap matters
  always @(negedge ref_clk) begin
    tx_ready <= stall ? (($random(seed) % 4) != 0) : 1'b1;
  end
  // Capture every accepted reply or echo byte
  always @(posedge ref_clk) begin
    if (tx_valid === 1'b1 && tx_ready) begin
      acc <= {acc[151:0], tx_data};
      n <= n + 1;
    end
  end
  // One byte per pulse, then a gap; idle data shows the inverse of the last byte
  task automatic send_byte(input logic [7:0] b);
    @(negedge ref_clk);
    rx_valid = 1'b1;
    rx_data = b;
    @(negedge ref_clk);
    rx_valid = 1'b0;
    rx_data = ~b;
    repeat (6) @(negedge ref_clk);
  endtask : send_byte
endmodule : scc_host_model

// >>> serial_config_command_mode_tb.sv
// Self-checking testbench for the serial configuration command interpreter
`timescale 1ns/1ps
module serial_config_command_mode_tb;
  localparam int INIT = 32;
  logic ref_clk, rstn, link_up, config_trigger_pin, pin, oe_q;
  logic rx_valid, tx_ready, tx_valid, pin_out, oe, in_config, close_conn, save_req, reboot_req;
  logic [7:0] rx_data, tx_data;
  int bad_count, compares, seed, ncl, nsv, nrb, noff, nv;
  string v;
  // Pull-up on the trigger wire; the host pulls it low to request configuration
  assign pin = oe ? pin_out : !config_trigger_pin;
  scc_command_mode #(.INIT_CYCLES(INIT)) u_dut (.ref_clk(ref_clk), .rstn(rstn),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready), .link_up(link_up),
    .config_trigger_pin_in(pin), .tx_valid(tx_valid), .tx_data(tx_data),
    .config_trigger_pin_out(pin_out), .config_trigger_pin_oe(oe), .in_config(in_config),
    .close_conn(close_conn), .save_req(save_req), .reboot_req(reboot_req));
  scc_host_model u_host (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Pulse and pin-release counters
  always @(posedge ref_clk) begin
    oe_q <= oe;
    if (close_conn === 1'b1) ncl++;
    if (save_req === 1'b1) nsv++;
    if (reboot_req === 1'b1) nrb++;
    if (oe_q === 1'b1 && oe === 1'b0) noff++;
  end
  task automatic check(input string name, input logic [159:0] seen, input logic [159:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  function automatic logic [159:0] to_vec(input string s);
    logic [159:0] r;
    r = '0;
    for (int i = 0; i < s.len(); i++) r = {r[151:0], 8'(s[i])};
    return r;
  endfunction : to_vec
  // Send a line, wait for the expected byte count, then compare the whole capture
  task automatic run(input string name, input string s, input string e);
    int t;
    @(negedge ref_clk);
    u_host.acc = '0;
    u_host.n = 0;
    for (int i = 0; i < s.len(); i++) u_host.send_byte(8'(s[i]));
    t = 0;
    while (u_host.n < e.len() && t < 400) begin
      @(negedge ref_clk);
      t++;
    end
    // Scaled-down pause between commands; also catches stray late bytes
    repeat (30) @(negedge ref_clk);
    check({name, " count"}, u_host.n, e.len());
    check(name, u_host.acc, to_vec(e));
    $display("test %s done", name);
  endtask : run
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    {bad_count, compares, ncl, nsv, nrb, noff} = '0;
    seed = 72;
    rstn = 1'b0;
    link_up = 1'b0;
    config_trigger_pin = 1'b1;
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (INIT + 4) @(negedge ref_clk);
    config_trigger_pin = 1'b0;
    check("strap entry", in_config, 1);
    check("strap close", ncl, 1);
    check("pin driven", oe, 1);
    $display("test strap done");
    for (int i = 0; i < 6; i++) begin
      link_up = 1'($random(seed));
      repeat (2) @(negedge ref_clk);
      check("status pin", pin, !link_up);
    end
    $display("test status done");
    run("query sp", "SP\r\n", "SP110\r\n");
    run("query li", "LI\r\n", "LI192.168.11.2\r\n");
    v = "";
    nv = 1 + ($unsigned($random(seed)) % 4);
    for (int i = 0; i < nv; i++)
      v = {v, string'(8'h30 + 8'($unsigned($random(seed)) % 10))};
    run("set sp", {"SP", v, "\r\n"}, "");
    run("readback sp", "SP\r\n", {"SP", v, "\r\n"});
    run("lf only", "SP\n", "");
    run("unknown", "ZZ\r\n", "");
    run("save", "SV\r\n", "");
    check("save pulse", nsv, 1);
    // Scaled-down settle time after a save
    repeat (60) @(negedge ref_clk);
    run("exit", "EX\r\n", "");
    check("exit mode", in_config, 0);
    run("soft trigger", "+++", "");
    check("soft entry", in_config, 1);
    check("soft close", ncl, 2);
    run("echo on", "EC1\r\n", "");
    run("query ec", "EC\r\n", "EC1\r\n");
    run("reboot", "RT\r\n", "REBOOT\r\n");
    check("reboot pulse", nrb, 1);
    check("pin released", noff, 1);
    repeat (INIT + 4) @(negedge ref_clk);
    check("reboot mode", in_config, 0);
    check("pin driven again", oe, 1);
    run("soft again", "+++", "");
    u_host.stall = 1'b0;
    run("echo", "LI", "LI");
    give_verdict();
  end
endmodule : serial_config_command_mode_tb
